// ---- verilog/cmx_top.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Invert bit seven flips comparator output
// - Inverted level feeds events, pad, state, flag
// - Positive select bit three picks pin
// - Negative select code picks pin, reference, converter
// - Enable bit zero gates interrupt request
// - State bit four shows synchronised level
// - Writing one to flag clears it
// - Edge mode chooses edges that set flag
// - Request stays high until flag or enable bit zero cleared
// - Standby run: events update, status frozen
// - Enabled comparator drives output event, except in standby with standby run clear
module cmx_top
  import cmx_pkg::*;
(
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Register port.
  input  wire cmx_bus_req_t bus_req,
  output logic [7:0]        rdata,
  // Comparator core.
  input  wire logic         cmp_raw,
  output cmx_mux_sel_t      mux_sel,
  output logic              cmp_enable,
  // Sleep control.
  input  wire logic         standby,
  // Outputs to the system.
  output logic              event_out,
  output logic              pad_out,
  output logic              pad_en,
  output logic              irq
);

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [7:0] ctrl_reg;
  logic [7:0] mux_reg;
  logic [7:0] irq_en_reg;
  logic       flag_reg;
  logic       flag_next;
  logic       sync1_reg;
  logic       sync2_reg;
  logic       state_reg;
  logic       state_prev_reg;
  logic [7:0] rdata_reg;
  logic       irq_reg;
  logic       event_reg;
  logic       pad_out_reg;
  logic       pad_en_reg;
  logic       level;
  logic       run_events;
  logic       run_status;
  logic       rise;
  logic       fall;
  logic       edge_hit;
  logic       clear_hit;
  logic [1:0] edge_mode;

  assign edge_mode  = ctrl_reg[CMX_BIT_EDGE_LO +: 2];
  assign run_events = !standby || ctrl_reg[CMX_BIT_STBY_RUN];
  assign run_status = !standby;
  assign level      = sync2_reg ^ mux_reg[CMX_BIT_INVERT];

  // ****************************************************************
  // Register writes.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg   <= CMX_RST_CTRL;
      mux_reg    <= CMX_RST_MUX;
      irq_en_reg <= CMX_RST_IRQ_EN;
    end
    else if (bus_req.wr)
    begin
      case (bus_req.addr)
        CMX_OFS_CTRL:   ctrl_reg   <= bus_req.wdata & CMX_MASK_CTRL;
        CMX_OFS_MUX:    mux_reg    <= bus_req.wdata & CMX_MASK_MUX;
        CMX_OFS_IRQ_EN: irq_en_reg <= bus_req.wdata & CMX_MASK_IRQ_EN;
        default:        ;
      endcase
    end
  end

  // ****************************************************************
  // Register reads.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_reg <= 8'h00;
    else if (bus_req.rd)
    begin
      case (bus_req.addr)
        CMX_OFS_CTRL:   rdata_reg <= ctrl_reg;
        CMX_OFS_MUX:    rdata_reg <= mux_reg;
        CMX_OFS_IRQ_EN: rdata_reg <= irq_en_reg;
        CMX_OFS_STATUS:
          rdata_reg <= {3'h0, state_reg, 3'h0, flag_reg};
        default:        rdata_reg <= 8'h00;
      endcase
    end
    else
      rdata_reg <= 8'h00;
  end

  // ****************************************************************
  // Comparator output synchroniser and state.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= cmp_raw;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg      <= 1'b0;
      state_prev_reg <= 1'b0;
    end
    else if (run_status)
    begin
      state_reg      <= level;
      state_prev_reg <= state_reg;
    end
  end

  // ****************************************************************
  // Interrupt flag.
  // ****************************************************************
  assign rise = state_reg && !state_prev_reg;
  assign fall = !state_reg && state_prev_reg;

  always_comb
  begin
    case (edge_mode)
      CMX_EDGE_ANY:  edge_hit = rise || fall;
      CMX_EDGE_FALL: edge_hit = fall;
      CMX_EDGE_RISE: edge_hit = rise;
      default:       edge_hit = 1'b0;
    endcase
  end

  assign clear_hit = bus_req.wr && (bus_req.addr == CMX_OFS_STATUS)
                     && bus_req.wdata[CMX_BIT_CMP_IRQ];

  always_comb
  begin
    flag_next = flag_reg;
    if (run_status)
    begin
      if (clear_hit)
        flag_next = 1'b0;
      if (edge_hit && ctrl_reg[CMX_BIT_ENABLE])
        flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_en_reg[CMX_BIT_CMP_IRQ] && flag_reg;
  end

  // ****************************************************************
  // Event and pad outputs.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      event_reg   <= 1'b0;
      pad_out_reg <= 1'b0;
      pad_en_reg  <= 1'b0;
    end
    else if (run_events)
    begin
      event_reg   <= ctrl_reg[CMX_BIT_ENABLE] && level;
      pad_out_reg <= ctrl_reg[CMX_BIT_ENABLE] && level;
      pad_en_reg  <= ctrl_reg[CMX_BIT_ENABLE] && ctrl_reg[CMX_BIT_PAD_EN];
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign rdata                         = rdata_reg;
  assign mux_sel.positive_input_select = mux_reg[CMX_BIT_POS_SEL];
  assign mux_sel.negative_input_select = mux_reg[CMX_BIT_NEG_LO +: 2];
  assign cmp_enable                    = ctrl_reg[CMX_BIT_ENABLE];
  assign event_out                     = event_reg;
  assign pad_out                       = pad_out_reg;
  assign pad_en                        = pad_en_reg;
  assign irq                           = irq_reg;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  inverted_event_a: assert property (
    ctrl_reg[CMX_BIT_ENABLE] && run_events
    |=> event_out == ($past(sync2_reg) ^ $past(mux_reg[CMX_BIT_INVERT])))
    else $error("Event output does not follow the inverted level.");

  positive_select_a: assert property (
    bus_req.wr && bus_req.addr == CMX_OFS_MUX
    |=> mux_sel.positive_input_select == $past(bus_req.wdata[CMX_BIT_POS_SEL]))
    else $error("Positive input select did not take the written bit.");

  negative_select_a: assert property (
    bus_req.wr && bus_req.addr == CMX_OFS_MUX
    |=> mux_sel.negative_input_select == $past(bus_req.wdata[1:0]))
    else $error("Negative input select did not take the written code.");

  irq_gate_a: assert property (
    !irq_en_reg[CMX_BIT_CMP_IRQ] |=> !irq)
    else $error("Interrupt raised while disabled.");

  irq_hold_a: assert property (
    irq_en_reg[CMX_BIT_CMP_IRQ] && flag_reg |=> irq)
    else $error("Interrupt request dropped while flag and enable are set.");

  state_delay_a: assert property (
    $past(rst_n, 3) && $past(run_status) && $stable(mux_reg[CMX_BIT_INVERT])
    |-> state_reg == ($past(cmp_raw, 3) ^ $past(mux_reg[CMX_BIT_INVERT])))
    else $error("State bit does not show the level three cycles back.");

  flag_clear_a: assert property (
    clear_hit && run_status && !edge_hit |=> !flag_reg)
    else $error("Flag not cleared by a one write.");

  rise_sets_a: assert property (
    rise && edge_mode == CMX_EDGE_RISE && ctrl_reg[CMX_BIT_ENABLE] && run_status
    |=> flag_reg)
    else $error("Rising edge did not set the flag.");

  reserved_mode_a: assert property (
    !flag_reg && edge_mode == CMX_EDGE_RESERVED |=> !flag_reg)
    else $error("Reserved edge mode set the flag.");

  standby_hold_a: assert property (
    standby |=> $stable(flag_reg))
    else $error("Status changed during standby.");

  event_off_a: assert property (
    !ctrl_reg[CMX_BIT_ENABLE] && run_events |=> !event_out)
    else $error("Event driven while comparator disabled.");

  zero_write_a: assert property (
    bus_req.wr && bus_req.addr == CMX_OFS_STATUS
    && !bus_req.wdata[CMX_BIT_CMP_IRQ] && !edge_hit |=> $stable(flag_reg))
    else $error("Zero write changed the flag.");

  state_freeze_a: assert property (
    standby |=> $stable(state_reg))
    else $error("State bit changed during standby.");

  event_hold_a: assert property (
    standby && !ctrl_reg[CMX_BIT_STBY_RUN] |=> $stable(event_out) && $stable(pad_out))
    else $error("Event or pad output changed in halted standby.");

  pad_follow_a: assert property (
    run_events
    |=> pad_out == ($past(ctrl_reg[CMX_BIT_ENABLE])
                    && ($past(sync2_reg) ^ $past(mux_reg[CMX_BIT_INVERT]))))
    else $error("Pad output does not follow the inverted level.");

  set_wins_a: assert property (
    edge_hit && ctrl_reg[CMX_BIT_ENABLE] && run_status |=> flag_reg)
    else $error("Selected edge did not set the flag.");

  irq_follow_a: assert property (
    !flag_reg |=> !irq)
    else $error("Interrupt raised with the flag clear.");

endmodule

// ---- pkg/cmx_pkg.sv ----
package cmx_pkg;

  // ****************************************************************
  // Register map and field layout.
  // ****************************************************************
  localparam int          CMX_AW            = 8;
  localparam int          CMX_DW            = 8;
  localparam logic [7:0]  CMX_OFS_CTRL      = 8'h00;
  localparam logic [7:0]  CMX_OFS_MUX       = 8'h02;
  localparam logic [7:0]  CMX_OFS_IRQ_EN    = 8'h06;
  localparam logic [7:0]  CMX_OFS_STATUS    = 8'h07;
  localparam logic [7:0]  CMX_RST_CTRL      = 8'h00;
  localparam logic [7:0]  CMX_RST_MUX       = 8'h00;
  localparam logic [7:0]  CMX_RST_IRQ_EN    = 8'h00;
  localparam logic [7:0]  CMX_RST_STATUS    = 8'h00;
  localparam logic [7:0]  CMX_MASK_CTRL     = 8'hF1;
  localparam logic [7:0]  CMX_MASK_MUX      = 8'h8B;
  localparam logic [7:0]  CMX_MASK_IRQ_EN   = 8'h01;
  localparam int          CMX_BIT_ENABLE    = 0;
  localparam int          CMX_BIT_EDGE_LO   = 4;
  localparam int          CMX_BIT_PAD_EN    = 6;
  localparam int          CMX_BIT_STBY_RUN  = 7;
  localparam int          CMX_BIT_INVERT    = 7;
  localparam int          CMX_BIT_POS_SEL   = 3;
  localparam int          CMX_BIT_NEG_LO    = 0;
  localparam int          CMX_BIT_CMP_IRQ   = 0;
  localparam int          CMX_BIT_STATE     = 4;
  localparam int          CMX_SYNC_CYCLES   = 3;

  // ****************************************************************
  // Edge and negative input encodings.
  // ****************************************************************
  localparam logic [1:0]  CMX_EDGE_ANY      = 2'h0;
  localparam logic [1:0]  CMX_EDGE_RESERVED = 2'h1;
  localparam logic [1:0]  CMX_EDGE_FALL     = 2'h2;
  localparam logic [1:0]  CMX_EDGE_RISE     = 2'h3;
  localparam logic [1:0]  CMX_NEG_PIN_ZERO  = 2'h0;
  localparam logic [1:0]  CMX_NEG_PIN_ONE   = 2'h1;
  localparam logic [1:0]  CMX_NEG_VREF      = 2'h2;
  localparam logic [1:0]  CMX_NEG_DAC       = 2'h3;

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cmx_bus_req_t;

  typedef struct packed {
    logic       positive_input_select;
    logic [1:0] negative_input_select;
  } cmx_mux_sel_t;

endpackage

// ---- verification/cmx_core_model.sv ----
`timescale 1ns/1ps
module cmx_core_model
  import cmx_pkg::*;
(
  // Selects and enable from the block.
  input  wire cmx_mux_sel_t mux_sel,
  input  wire logic         cmp_enable,
  // Pin and internal source levels.
  input  wire logic [1:0]   pos_pins,
  input  wire logic [3:0]   neg_pins,
  // Comparator result.
  output logic              cmp_raw
);
  // ****************************************************************
  // With the comparator enabled, a high positive source over a low negative source gives a one.
  // ****************************************************************
  assign cmp_raw = cmp_enable & pos_pins[mux_sel.positive_input_select]
                   & ~neg_pins[mux_sel.negative_input_select];
endmodule

// ---- verification/cmx_tb_top.sv ----
`timescale 1ns/1ps
module cmx_tb_top
  import cmx_pkg::*;
;
  // ****************************************************************
  // Signals.
  // ****************************************************************
  logic         clk;
  logic         rst_n;
  cmx_bus_req_t bus_req;
  logic [7:0]   rdata;
  logic         cmp_raw;
  cmx_mux_sel_t mux_sel;
  logic         cmp_enable;
  logic         standby;
  logic         event_out;
  logic         pad_out;
  logic         pad_en;
  logic         irq;
  logic [1:0]   pos_pins;
  logic [3:0]   neg_pins;
  logic         fl;
  int           n_errors;
  int           check_count;
  int           cycles = 0;

  cmx_top cmx_top_i (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .cmp_raw(cmp_raw), .mux_sel(mux_sel), .cmp_enable(cmp_enable), .standby(standby),
    .event_out(event_out), .pad_out(pad_out), .pad_en(pad_en), .irq(irq));
  cmx_core_model cmx_core_model_i (.mux_sel(mux_sel), .cmp_enable(cmp_enable),
    .pos_pins(pos_pins), .neg_pins(neg_pins), .cmp_raw(cmp_raw));

  // ****************************************************************
  // Clock, timeout and tasks.
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask

  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask

  // ****************************************************************
  // Tests.
  // ****************************************************************
  initial
  begin
    bus_req = '0;
    standby = 1'b0;
    pos_pins = 2'b11;
    neg_pins = 4'hF;
    n_errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(CMX_OFS_CTRL, CMX_RST_CTRL, "ctrl reset");
    rd(CMX_OFS_MUX, CMX_RST_MUX, "mux reset");
    rd(CMX_OFS_IRQ_EN, CMX_RST_IRQ_EN, "irq_en reset");
    rd(CMX_OFS_STATUS, CMX_RST_STATUS, "status reset");
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h00, "unmapped");
    wr(CMX_OFS_MUX, 8'hFF);
    rd(CMX_OFS_MUX, 8'h8B, "mux bits");
    chk("event disabled", 8'h00, {7'h00, event_out});
    wr(CMX_OFS_IRQ_EN, 8'hFF);
    rd(CMX_OFS_IRQ_EN, 8'h01, "irq_en bits");
    $display("register test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(CMX_OFS_MUX, {4'h0, i[2], 1'b0, i[1:0]});
      chk("pos select", {7'h00, i[2]}, {7'h00, mux_sel.positive_input_select});
      chk("neg select", {6'h00, i[1:0]}, {6'h00, mux_sel.negative_input_select});
    end
    $display("select test done");
    wr(CMX_OFS_MUX, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      wr(CMX_OFS_CTRL, {2'b01, m[1:0], 4'h1});
      for (int e = 0; e < 2; e++)
      begin
        wr(CMX_OFS_STATUS, 8'h01);
        neg_pins <= {3'h7, e[0]};
        settle();
        fl = (m == 0) || (m == 2 && e == 1) || (m == 3 && e == 0);
        rd(CMX_OFS_STATUS, {3'h0, e == 0, 3'h0, fl}, "status edge");
        chk("event", {7'h00, e == 0}, {7'h00, event_out});
        chk("pad", {6'h00, 1'b1, e == 0}, {6'h00, pad_en, pad_out});
        chk("irq", {7'h00, fl}, {7'h00, irq});
        wr(CMX_OFS_STATUS, 8'hFE);
        rd(CMX_OFS_STATUS, {3'h0, e == 0, 3'h0, fl}, "zero write");
      end
    end
    $display("edge test done");
    wr(CMX_OFS_CTRL, 8'h41);
    chk("cmp enable", 8'h01, {7'h00, cmp_enable});
    neg_pins <= 4'hE;
    settle();
    wr(CMX_OFS_IRQ_EN, 8'h00);
    settle();
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(CMX_OFS_MUX, 8'h80);
    settle();
    rd(CMX_OFS_STATUS, 8'h01, "inverted state");
    chk("inverted event", 8'h00, {7'h00, event_out});
    $display("invert test done");
    wr(CMX_OFS_CTRL, 8'hC1);
    wr(CMX_OFS_IRQ_EN, 8'h01);
    wr(CMX_OFS_STATUS, 8'h01);
    standby <= 1'b1;
    neg_pins <= 4'hF;
    settle();
    chk("standby event", 8'h01, {7'h00, event_out});
    rd(CMX_OFS_STATUS, 8'h00, "standby status");
    chk("standby irq", 8'h00, {7'h00, irq});
    wr(CMX_OFS_CTRL, 8'h41);
    neg_pins <= 4'hE;
    settle();
    chk("halted event", 8'h01, {7'h00, event_out});
    chk("halted pad", 8'h01, {7'h00, pad_out});
    $display("standby test done");
    close_out();
  end
endmodule
